//--- phbp_pkg.sv
// Shared constants and types for the parallel host bus port.
package phbp_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int SEL_W = 5;
    localparam int TEST_N = 2 ** SEL_W;
    localparam int SW_ADDR_W = 4;

    typedef enum logic [2:0] {
        PHBP_NONE,
        PHBP_SEP_DED,
        PHBP_SEP_MUX,
        PHBP_COM_DED,
        PHBP_COM_MUX,
        PHBP_EPP
    } phbp_mode_t;

    // Board ties on address pins 2..0 that mark the multiplexed styles.
    localparam logic [2:0] STRAP_SEP_MUX = 3'h3;
    localparam logic [2:0] STRAP_COM_MUX = 3'h2;
    localparam logic [1:0] STRAP_EPP_HI = 2'h3;
    localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;

    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_PHASE_NS = 200;
    localparam int RESET_PHASE_CYC =
        (RESET_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE_NS = 40;
    localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Internal address of the test selection register.
    localparam logic [ADDR_W-1:0] TEST_SEL_ADDR = 6'h3F;

    // Controller registers seen by software.
    localparam logic [SW_ADDR_W-1:0] HREG_MODE = 4'h0;
    localparam logic [SW_ADDR_W-1:0] HREG_ADDR = 4'h1;
    localparam logic [SW_ADDR_W-1:0] HREG_WDATA = 4'h2;
    localparam logic [SW_ADDR_W-1:0] HREG_READ = 4'h3;
    localparam logic [SW_ADDR_W-1:0] HREG_STATUS = 4'h4;
    localparam logic [SW_ADDR_W-1:0] HREG_RDATA = 4'h5;
    localparam int MODE_PD_BIT = 3;
endpackage

//--- phbp_if.sv
// Pin bundle between the reader port and its host, with wire resolution.
`timescale 1ns/10ps
interface phbp_if;
    logic addr_latch_pin;
    logic [2:1] addr_pin_hi;
    logic host_a0_o;
    logic host_a0_oe;
    logic cycle_wait_out;
    logic cycle_wait_oe;
    logic a0_lvl;
    logic read_strobe_n;
    logic write_strobe_n;
    logic chip_select_n;
    logic reset_powerdown_in;
    logic [phbp_pkg::DATA_W-1:0] host_bus_o;
    logic host_bus_oe;
    logic [phbp_pkg::DATA_W-1:0] dev_bus_o;
    logic dev_bus_oe;
    logic [phbp_pkg::DATA_W-1:0] mux_addr_data_bus;

    // Undriven lines rest high, as with board pull-ups.
    assign mux_addr_data_bus = dev_bus_oe ? dev_bus_o :
        (host_bus_oe ? host_bus_o : phbp_pkg::BUS_IDLE);
    assign a0_lvl = cycle_wait_oe ? cycle_wait_out :
        (host_a0_oe ? host_a0_o : 1'b1);

    modport dev_mp (
        input addr_latch_pin, addr_pin_hi, a0_lvl, read_strobe_n,
        input write_strobe_n, chip_select_n, reset_powerdown_in,
        input mux_addr_data_bus,
        output cycle_wait_out, cycle_wait_oe, dev_bus_o, dev_bus_oe
    );
    modport host_mp (
        output addr_latch_pin, addr_pin_hi, host_a0_o, host_a0_oe,
        output read_strobe_n, write_strobe_n, chip_select_n,
        output reset_powerdown_in, host_bus_o, host_bus_oe,
        input a0_lvl, mux_addr_data_bus
    );
endinterface

//--- phbp_host.sv
// Host end: drives one of the five bus styles from software orders.
`timescale 1ns/10ps
module phbp_host #(
    parameter int PHASE = phbp_pkg::PHASE_CYC,
    parameter int STROBE = phbp_pkg::STROBE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    phbp_if.host_mp pins,
    input wire logic [phbp_pkg::SW_ADDR_W-1:0] sw_addr,
    input wire logic [phbp_pkg::DATA_W-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [phbp_pkg::DATA_W-1:0] sw_rdata
);
    localparam int CW = $clog2(STROBE + PHASE + 1);
    if (PHASE < 1 || STROBE < 4) begin : g_chk
        $error("PHASE must be >= 1 and STROBE >= 4");
    end

    typedef enum logic [2:0] {
        H_IDLE, H_ADDR, H_ADDR_END, H_STROBE, H_DONE
    } phbp_hstate_t;

    phbp_hstate_t state_r;
    phbp_pkg::phbp_mode_t mode_r;
    logic pd_r;
    logic is_rd_r;
    logic [CW-1:0] cnt_r;
    logic [phbp_pkg::ADDR_W-1:0] addr_r;
    logic [phbp_pkg::DATA_W-1:0] wdata_r;
    logic [phbp_pkg::DATA_W-1:0] rdata_r;
    logic [phbp_pkg::DATA_W-1:0] sw_rdata_r;
    logic go;
    logic muxed;
    logic epp;
    logic busy;

    assign busy = state_r != H_IDLE;
    assign epp = mode_r == phbp_pkg::PHBP_EPP;
    assign muxed = epp || mode_r == phbp_pkg::PHBP_SEP_MUX ||
        mode_r == phbp_pkg::PHBP_COM_MUX;
    assign go = sw_wr && !busy && !pd_r && mode_r != phbp_pkg::PHBP_NONE &&
        (sw_addr == phbp_pkg::HREG_WDATA || sw_addr == phbp_pkg::HREG_READ);
    assign sw_rdata = sw_rdata_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_r <= phbp_pkg::PHBP_NONE;
            pd_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (sw_wr && !busy) begin
            case (sw_addr)
                phbp_pkg::HREG_MODE: begin
                    mode_r <= phbp_pkg::phbp_mode_t'(sw_wdata[2:0]);
                    pd_r <= sw_wdata[phbp_pkg::MODE_PD_BIT];
                end
                phbp_pkg::HREG_ADDR: addr_r <= sw_wdata[phbp_pkg::ADDR_W-1:0];
                phbp_pkg::HREG_WDATA: wdata_r <= sw_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sw_rdata_r <= '0;
        end else if (!sw_rd) begin
            sw_rdata_r <= '0;
        end else begin
            case (sw_addr)
                phbp_pkg::HREG_MODE: sw_rdata_r <= {4'h0, pd_r, mode_r};
                phbp_pkg::HREG_ADDR: sw_rdata_r <= {2'h0, addr_r};
                phbp_pkg::HREG_WDATA: sw_rdata_r <= wdata_r;
                phbp_pkg::HREG_STATUS: sw_rdata_r <= {7'h00, busy};
                phbp_pkg::HREG_RDATA: sw_rdata_r <= rdata_r;
                default: sw_rdata_r <= '0;
            endcase
        end
    end

    // Cycle sequencer; EPP phases wait on the device's wait line.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= H_IDLE;
            cnt_r <= '0;
            is_rd_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
            case (state_r)
                H_IDLE: begin
                    cnt_r <= '0;
                    if (go) begin
                        is_rd_r <= sw_addr == phbp_pkg::HREG_READ;
                        state_r <= muxed ? H_ADDR : H_STROBE;
                    end
                end
                H_ADDR: if (epp ? pins.a0_lvl : cnt_r == CW'(PHASE)) begin
                    state_r <= H_ADDR_END;
                    cnt_r <= '0;
                end
                H_ADDR_END: if (epp ? !pins.a0_lvl : 1'b1) begin
                    state_r <= H_STROBE;
                    cnt_r <= '0;
                end
                H_STROBE: if (epp ? pins.a0_lvl : cnt_r == CW'(STROBE)) begin
                    rdata_r <= is_rd_r ? pins.mux_addr_data_bus : rdata_r;
                    state_r <= H_DONE;
                    cnt_r <= '0;
                end
                H_DONE: if (epp ? !pins.a0_lvl : cnt_r == CW'(PHASE)) begin
                    state_r <= H_IDLE;
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    // Pin levels follow the sequencer state one cycle later.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pins.addr_latch_pin <= 1'b1;
            pins.addr_pin_hi <= '0;
            pins.host_a0_o <= 1'b0;
            pins.host_a0_oe <= 1'b0;
            pins.read_strobe_n <= 1'b1;
            pins.write_strobe_n <= 1'b1;
            pins.chip_select_n <= 1'b1;
            pins.reset_powerdown_in <= 1'b0;
            pins.host_bus_o <= '0;
            pins.host_bus_oe <= 1'b0;
        end else begin
            pins.reset_powerdown_in <= pd_r;
            pins.host_bus_o <= (state_r == H_STROBE) ? wdata_r : {2'h0, addr_r};
            pins.host_bus_oe <= state_r == H_ADDR || state_r == H_ADDR_END ||
                (state_r == H_STROBE && !is_rd_r);
            pins.host_a0_oe <= !epp;
            pins.chip_select_n <= epp ? 1'b0 : state_r != H_STROBE;
            pins.read_strobe_n <= state_r != H_STROBE;
            case (mode_r)
                phbp_pkg::PHBP_SEP_DED, phbp_pkg::PHBP_COM_DED: begin
                    pins.addr_latch_pin <= 1'b1;
                    {pins.addr_pin_hi, pins.host_a0_o} <= addr_r[2:0];
                end
                phbp_pkg::PHBP_SEP_MUX: begin
                    pins.addr_latch_pin <= state_r == H_ADDR;
                    {pins.addr_pin_hi, pins.host_a0_o} <= phbp_pkg::STRAP_SEP_MUX;
                end
                phbp_pkg::PHBP_COM_MUX: begin
                    pins.addr_latch_pin <= state_r == H_ADDR;
                    {pins.addr_pin_hi, pins.host_a0_o} <= phbp_pkg::STRAP_COM_MUX;
                end
                phbp_pkg::PHBP_EPP: begin
                    pins.addr_latch_pin <= state_r != H_ADDR;
                    pins.addr_pin_hi <= phbp_pkg::STRAP_EPP_HI;
                    pins.host_a0_o <= 1'b0;
                end
                default: begin
                    pins.addr_latch_pin <= 1'b1;
                    {pins.addr_pin_hi, pins.host_a0_o} <= 3'h0;
                end
            endcase
            case (mode_r)
                phbp_pkg::PHBP_SEP_DED, phbp_pkg::PHBP_SEP_MUX: begin
                    pins.read_strobe_n <= !(state_r == H_STROBE && is_rd_r);
                    pins.write_strobe_n <= !(state_r == H_STROBE && !is_rd_r);
                end
                phbp_pkg::PHBP_COM_DED, phbp_pkg::PHBP_COM_MUX:
                    pins.write_strobe_n <= state_r != H_STROBE || is_rd_r;
                // Address cycles are always writes here.
                phbp_pkg::PHBP_EPP: pins.write_strobe_n <= state_r != H_ADDR &&
                    (state_r != H_STROBE || is_rd_r);
                default: pins.write_strobe_n <= 1'b1;
            endcase
        end
    end
endmodule // phbp_host

//--- phbp_device.sv
// Reader-chip end: bus style detection, address latch, strobes and wait.
`timescale 1ns/10ps
module phbp_device #(
    parameter int RST_CYC = phbp_pkg::RESET_PHASE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    phbp_if.dev_mp pins,
    input wire logic cfg_common_strobe,
    input wire logic [phbp_pkg::TEST_N-1:0] test_sig_in,
    input wire logic [phbp_pkg::DATA_W-1:0] reg_rdata,
    output logic [phbp_pkg::ADDR_W-1:0] reg_addr,
    output logic [phbp_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [phbp_pkg::SEL_W-1:0] test_signal_select,
    output logic aux_out,
    output phbp_pkg::phbp_mode_t bus_mode,
    output logic powered_down
);
    localparam int CW = $clog2(RST_CYC + 1);
    if (RST_CYC < 1) begin : g_chk
        $error("RST_CYC must be at least one");
    end

    logic [CW-1:0] cnt_r;
    phbp_pkg::phbp_mode_t mode_r;
    logic pd_r;
    logic ale_q;
    logic act_q;
    logic rd_q;
    logic as_q;
    logic data_ok_r;
    logic wait_en_r;
    logic wait_o_r;
    logic bus_oe_r;
    logic [phbp_pkg::DATA_W-1:0] bus_o_r;
    logic [phbp_pkg::ADDR_W-1:0] addr_r;
    logic [phbp_pkg::DATA_W-1:0] wdata_r;
    logic reg_wr_r;
    logic reg_rd_r;
    logic [phbp_pkg::SEL_W-1:0] test_sel_r;
    logic aux_r;
    logic act;
    logic rd;
    logic as_act;

    // Strap decode. The handshake style is checked first because its
    // idle address strobe rests high like a tied latch pin.
    function automatic phbp_pkg::phbp_mode_t detect(
        input logic ale,
        input logic [2:0] apin,
        input logic cs_n,
        input logic common
    );
        phbp_pkg::phbp_mode_t m;
        m = phbp_pkg::PHBP_NONE;
        if (apin[2:1] == phbp_pkg::STRAP_EPP_HI && !cs_n) begin
            m = phbp_pkg::PHBP_EPP;
        end else if (ale) begin
            m = common ? phbp_pkg::PHBP_COM_DED : phbp_pkg::PHBP_SEP_DED;
        end else if (apin == phbp_pkg::STRAP_SEP_MUX) begin
            m = phbp_pkg::PHBP_SEP_MUX;
        end else if (apin == phbp_pkg::STRAP_COM_MUX) begin
            m = phbp_pkg::PHBP_COM_MUX;
        end
        return m;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pd_r <= 1'b0;
        end else begin
            pd_r <= pins.reset_powerdown_in;
        end
    end

    // The phase counter is held loaded during reset and while power-down is
    // high, so it starts running when reset ends or power-down falls.
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pins.reset_powerdown_in) begin
            cnt_r <= CW'(RST_CYC);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || pins.reset_powerdown_in) begin
            mode_r <= phbp_pkg::PHBP_NONE;
        end else if (cnt_r == CW'(1)) begin
            mode_r <= detect(pins.addr_latch_pin,
                {pins.addr_pin_hi, pins.a0_lvl}, pins.chip_select_n,
                cfg_common_strobe);
        end
    end

    // Access decode per style; no mode means every pin is ignored.
    always_comb begin
        act = 1'b0;
        rd = 1'b0;
        as_act = 1'b0;
        case (mode_r)
            phbp_pkg::PHBP_SEP_DED, phbp_pkg::PHBP_SEP_MUX: begin
                act = !pins.chip_select_n &&
                    (!pins.read_strobe_n || !pins.write_strobe_n);
                rd = !pins.read_strobe_n;
            end
            phbp_pkg::PHBP_COM_DED, phbp_pkg::PHBP_COM_MUX: begin
                act = !pins.chip_select_n && !pins.read_strobe_n;
                rd = pins.write_strobe_n;
            end
            phbp_pkg::PHBP_EPP: begin
                act = !pins.read_strobe_n && !pins.chip_select_n;
                rd = pins.write_strobe_n;
                as_act = !pins.addr_latch_pin;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ale_q <= 1'b1;
            act_q <= 1'b0;
            as_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            ale_q <= pins.addr_latch_pin;
            act_q <= act;
            as_q <= as_act;
            if (act && !act_q) begin
                rd_q <= rd;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addr_r <= '0;
        end else begin
            case (mode_r)
                phbp_pkg::PHBP_SEP_MUX, phbp_pkg::PHBP_COM_MUX:
                    if (pins.addr_latch_pin) begin
                        addr_r <= pins.mux_addr_data_bus[phbp_pkg::ADDR_W-1:0];
                    end
                phbp_pkg::PHBP_EPP:
                    if (as_act && !pins.write_strobe_n) begin
                        addr_r <= pins.mux_addr_data_bus[phbp_pkg::ADDR_W-1:0];
                    end
                phbp_pkg::PHBP_SEP_DED, phbp_pkg::PHBP_COM_DED:
                    addr_r <= {3'h0, pins.addr_pin_hi, pins.a0_lvl};
                default: ;
            endcase
        end
    end

    // Writes are committed when the strobe ends, using the last data seen.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wdata_r <= '0;
            reg_wr_r <= 1'b0;
            reg_rd_r <= 1'b0;
        end else begin
            if (act && !rd) begin
                wdata_r <= pins.mux_addr_data_bus;
            end
            reg_wr_r <= !act && act_q && !rd_q;
            reg_rd_r <= act && !act_q && rd;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_o_r <= '0;
            bus_oe_r <= 1'b0;
            data_ok_r <= 1'b0;
        end else begin
            bus_oe_r <= act && rd;
            if (reg_rd_r) begin
                bus_o_r <= reg_rdata;
            end
            data_ok_r <= act && (data_ok_r || reg_rd_r);
        end
    end

    // The wait line floats until the first falling address strobe.
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pins.reset_powerdown_in ||
            mode_r != phbp_pkg::PHBP_EPP) begin
            wait_en_r <= 1'b0;
            wait_o_r <= 1'b0;
        end else begin
            if (ale_q && !pins.addr_latch_pin) begin
                wait_en_r <= 1'b1;
            end
            // An address read is never acknowledged.
            wait_o_r <= (act && (rd ? data_ok_r : act_q)) ||
                (as_act && as_q && !pins.write_strobe_n);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            test_sel_r <= '0;
            aux_r <= 1'b0;
        end else begin
            if (reg_wr_r && addr_r == phbp_pkg::TEST_SEL_ADDR) begin
                test_sel_r <= wdata_r[phbp_pkg::SEL_W-1:0];
            end
            aux_r <= test_sig_in[test_sel_r];
        end
    end

    assign pins.dev_bus_o = bus_o_r;
    assign pins.dev_bus_oe = bus_oe_r;
    assign pins.cycle_wait_out = wait_o_r;
    assign pins.cycle_wait_oe = wait_en_r;
    assign reg_addr = addr_r;
    assign reg_wdata = wdata_r;
    assign reg_wr = reg_wr_r;
    assign reg_rd = reg_rd_r;
    assign test_signal_select = test_sel_r;
    assign aux_out = aux_r;
    assign bus_mode = mode_r;
    assign powered_down = pd_r;
endmodule // phbp_device

//--- phbp_properties.sv
// Concurrent checks on the pins joining the host and reader ends.
`timescale 1ns/10ps
module phbp_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic addr_latch_pin,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chip_select_n,
    input wire logic reset_powerdown_in,
    input wire logic cycle_wait_out,
    input wire logic cycle_wait_oe,
    input wire logic host_a0_oe,
    input wire logic host_bus_oe,
    input wire logic dev_bus_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic sel_rd;
    assign sel_rd = !read_strobe_n && !chip_select_n && write_strobe_n;
    AST_BUS_ONLY_ON_READ: assert property (
        dev_bus_oe |-> $past(sel_rd) || $past(sel_rd, 2) || $past(sel_rd, 3))
        else $error("data bus driven outside a selected read");
    AST_ONE_BUS_DRIVER: assert property (
        !(dev_bus_oe && host_bus_oe))
        else $error("both ends drive the data bus");
    AST_WAIT_FLOATS: assert property (
        $rose(reset_n) |-> !cycle_wait_oe [*8])
        else $error("wait pin driven right after reset");
    AST_WAIT_FROM_STROBE: assert property (
        $rose(cycle_wait_oe) |->
            !$past(addr_latch_pin) || !$past(addr_latch_pin, 2))
        else $error("wait pin driven without a low address strobe");
    AST_ACK_AFTER_STROBE: assert property (
        cycle_wait_oe && $rose(cycle_wait_out) |->
            $past(!read_strobe_n || !addr_latch_pin))
        else $error("wait raised with no strobe active");
    AST_WAIT_DROPS: assert property (
        cycle_wait_oe && $fell(cycle_wait_out) |->
            $past(read_strobe_n && addr_latch_pin))
        else $error("wait lowered while a strobe is active");
    AST_A0_ONE_DRIVER: assert property (
        !(cycle_wait_oe && host_a0_oe))
        else $error("both ends drive the address 0 pin");
    AST_POWERDOWN_INERT: assert property (
        reset_powerdown_in [*2] |-> !dev_bus_oe && !cycle_wait_oe)
        else $error("device drives pins while powered down");
    AST_STROBE_SELECTED: assert property (
        !read_strobe_n |-> !chip_select_n)
        else $error("data strobe active without chip select");
endmodule // phbp_properties

//--- parallel_host_bus_port_tb.sv
// Self-checking bench joining both port ends across the pin bundle.
`timescale 1ns/10ps
module parallel_host_bus_port_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [phbp_pkg::SW_ADDR_W-1:0] sw_addr = '0;
    logic [phbp_pkg::DATA_W-1:0] sw_wdata = '0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [phbp_pkg::DATA_W-1:0] sw_rdata;
    logic cfg_common_strobe = 1'b0;
    logic [phbp_pkg::TEST_N-1:0] test_sig_in = '0;
    logic [phbp_pkg::DATA_W-1:0] reg_rdata = '0;
    logic [phbp_pkg::ADDR_W-1:0] reg_addr;
    logic [phbp_pkg::DATA_W-1:0] reg_wdata;
    logic reg_wr, reg_rd, aux_out, powered_down;
    logic rd_seen = 1'b0;
    logic [27:0] mon_e;
    logic [13:0] mon_s;
    logic [phbp_pkg::SEL_W-1:0] test_signal_select;
    phbp_pkg::phbp_mode_t bus_mode;
    logic [27:0] wq[$];
    logic [7:0] rq[$];
    logic [5:0] aq[$];
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'h0000_c513;

    always #5 clk_sys = ~clk_sys;

    phbp_if phbp_if_inst ();
    phbp_host phbp_host_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .pins(phbp_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    phbp_device phbp_device_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .pins(phbp_if_inst), .cfg_common_strobe(cfg_common_strobe),
        .test_sig_in(test_sig_in), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .test_signal_select(test_signal_select),
        .aux_out(aux_out), .bus_mode(bus_mode),
        .powered_down(powered_down));
    phbp_properties phbp_properties_inst (.clk_sys(clk_sys),
        .reset_n(reset_n), .addr_latch_pin(phbp_if_inst.addr_latch_pin),
        .read_strobe_n(phbp_if_inst.read_strobe_n),
        .write_strobe_n(phbp_if_inst.write_strobe_n),
        .chip_select_n(phbp_if_inst.chip_select_n),
        .reset_powerdown_in(phbp_if_inst.reset_powerdown_in),
        .cycle_wait_out(phbp_if_inst.cycle_wait_out),
        .cycle_wait_oe(phbp_if_inst.cycle_wait_oe),
        .host_a0_oe(phbp_if_inst.host_a0_oe),
        .host_bus_oe(phbp_if_inst.host_bus_oe),
        .dev_bus_oe(phbp_if_inst.dev_bus_oe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    // Polls the busy flag, then lets the far end finish its pulses.
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 300 && s[0] !== 1'b0; i++) begin
            sw_read(phbp_pkg::HREG_STATUS, s);
        end
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic wait_mode();
        for (int i = 0; i < 100 && bus_mode === phbp_pkg::PHBP_NONE; i++) begin
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        if (reg_wr === 1'b1) begin
            mon_e = (wq.size() > 0) ? wq.pop_front() : 28'h000_3fff;
            mon_s = {reg_addr, reg_wdata} & mon_e[27:14];
            check(16'(mon_s), 16'(mon_e[13:0]));
        end
        if (reg_rd === 1'b1) begin
            if (aq.size() == 0) check(16'h0000, 16'h0001);
            else check(16'(reg_addr), 16'(aq.pop_front()));
        end
        if (rd_seen) begin
            if (rq.size() == 0) check(16'h0000, 16'h0001);
            else check(16'(sw_rdata), 16'(rq.pop_front()));
        end
        rd_seen <= (sw_rd === 1'b1) && (sw_addr === phbp_pkg::HREG_RDATA);
    end

    initial begin
        logic [5:0] a;
        logic [7:0] d;
        logic mux;
        test_sig_in <= $random(seed);
        for (int m = 1; m <= 5; m++) begin
            mux = (m == 2) || (m == 4) || (m == 5);
            @(posedge clk_sys);
            reset_n <= 1'b0;
            cfg_common_strobe <= (m == 3);
            repeat (3) @(posedge clk_sys);
            reset_n <= 1'b1;
            sw_write(phbp_pkg::HREG_MODE, 8'(m));
            wait_mode();
            check(16'(bus_mode), 16'(m));
            for (int k = 0; k < 3; k++) begin
                a = (mux && k == 2) ? phbp_pkg::TEST_SEL_ADDR : 6'($random(seed));
                // Dedicated styles carry only three address bits.
                if (!mux) a[5:3] = 3'h0;
                d = 8'($random(seed));
                wq.push_back({mux ? 6'h3f : 6'h07, 8'hff, a, d});
                sw_write(phbp_pkg::HREG_ADDR, 8'(a));
                sw_write(phbp_pkg::HREG_WDATA, d);
                wait_idle();
                if (mux && a == phbp_pkg::TEST_SEL_ADDR) begin
                    check(16'(test_signal_select), 16'(d[4:0]));
                    check(16'(aux_out), 16'(test_sig_in[d[4:0]]));
                end
                reg_rdata <= 8'($random(seed));
                @(posedge clk_sys);
                rq.push_back(reg_rdata);
                aq.push_back(a);
                sw_write(phbp_pkg::HREG_READ, 8'h00);
                wait_idle();
                sw_read(phbp_pkg::HREG_RDATA, d);
            end
            // Let the monitor take the last read note off its queue.
            repeat (2) @(posedge clk_sys);
            check(16'(wq.size() + rq.size()), 16'h0000);
            check(16'(aq.size()), 16'h0000);
            sw_write(phbp_pkg::HREG_MODE, 8'(m) | 8'h08);
            repeat (4) @(posedge clk_sys);
            check(16'(powered_down), 16'h0001);
            check(16'(bus_mode), 16'h0000);
            sw_write(phbp_pkg::HREG_MODE, 8'(m));
            wait_mode();
            check(16'(bus_mode), 16'(m));
        end
        complete_run();
    end

    initial begin
        #500000;
        error_cnt++;
        complete_run();
    end
endmodule // parallel_host_bus_port_tb
